// ===== core/sfr_regs.vh
// Purpose: constants for the search and feedback reporter
// Assumes: 32-bit AHB-Lite register bus, word aligned
// Notes: offsets are byte addresses
`ifndef SFR_REGS_VH
`define SFR_REGS_VH
// register offsets
`define SFR_CTRL_OFS      8'h00
`define SFR_STAT_OFS      8'h04
`define SFR_ALT_OFS       8'h08
`define SFR_IVAL_OFS      8'h0C
// control field positions
`define SFR_CTRL_CMD_LSB  0
`define SFR_CTRL_CNT_LSB  8
`define SFR_CTRL_SM_BIT   16
`define SFR_CTRL_RTS_BIT  17
`define SFR_CTRL_ICP_BIT  18
`define SFR_CTRL_NTF_BIT  19
`define SFR_CTRL_F_BIT    20
`define SFR_CTRL_GO_BIT   31
// reset values
`define SFR_CTRL_RST      32'h0000_0000
`define SFR_ALT_RST       2'h0
`define SFR_IVAL_RST      32'h1010_0A01
// result codes, attach code distinct from all others
`define SFR_CODE_OK       8'h00
`define SFR_CODE_DONE     8'h80
`define SFR_CODE_NORESP   8'h81
`define SFR_CODE_ATTACH   8'hA5
// feedback layout
`define SFR_STATE_BYTES   5'h10
`define SFR_RES_MAX       5'h10
`define SFR_ROM_BYTES     4'h8
`endif

// ===== core/sfr_top.v
// Purpose: search command tail and interrupt feedback assembly
// Assumes: engine pulses are one cycle, CE gates all state
// Notes: registers over AHB-Lite, zero wait states
//
// Functional notes
// RULE_01 - host gives bus command byte and device count byte
// RULE_02 - never discover more devices than the count allows
// RULE_03 - count of zero means search until every device found
// RULE_04 - host preloads eight identifier bytes before the search
// RULE_05 - search mode clear returns no output data bytes
// RULE_06 - search mode set returns IDs, then discrepancy if limited
// RULE_07 - on error with suppress clear, write done or no-response code
// RULE_08 - on success write zero only if suppress clear and notify set
// RULE_09 - no-response code when any bit position got no reply
// RULE_10 - flush on error clears command buffer and data FIFOs
// RULE_11 - host drains output FIFO during long searches
// RULE_12 - feedback leaves only through interrupt endpoint one
// RULE_13 - polling interval follows the selected alternate setting
// RULE_14 - at most 32 feedback bytes per transaction
// RULE_15 - 16 state bytes first, positions zero to fifteen
// RULE_16 - zero to sixteen result bytes at positions 16 to 31
// RULE_17 - fewer than 32 bytes ends with a short packet
// RULE_18 - results load only per command bits or attach detection
// RULE_19 - result count depends on bits, commands done, attaches
// RULE_20 - host tracks command order to read results
// RULE_21 - attach byte value differs from every result code
// RULE_22 - results kept in order, excess held for next poll

`timescale 1ns/1ps
`include "sfr_regs.vh"
module sfr_top (
  input  wire         CLK,
  input  wire         RST,
  input  wire         CE,
  input  wire         HSEL,
  input  wire [31:0]  HADDR,
  input  wire [1:0]   HTRANS,
  input  wire         HWRITE,
  input  wire [2:0]   HSIZE,
  input  wire [31:0]  HWDATA,
  input  wire         HREADY,
  output reg  [31:0]  HRDATA,
  output reg          HREADYOUT,
  output reg          HRESP,
  output reg          SRCH_GO,
  output reg  [7:0]   SRCH_CMD,
  output reg          SRCH_MODE,
  output reg          SRCH_STOP,
  input  wire         DEV_FOUND,
  input  wire [63:0]  DEV_ROM,
  input  wire         SRCH_END,
  input  wire         SRCH_MORE,
  input  wire [63:0]  SRCH_DISC,
  input  wire         SRCH_NORESP,
  output reg          FLUSH,
  output reg          OUT_VALID,
  output reg  [7:0]   OUT_DATA,
  input  wire         OUT_READY,
  input  wire         ATTACH,
  input  wire [127:0] STATE_IN,
  input  wire         EP1_IN,
  output reg          EP1_VALID,
  output reg  [7:0]   EP1_DATA,
  output reg          EP1_LAST,
  output reg  [7:0]   POLL_MS
);

  localparam ST_IDLE = 3'h0;
  localparam ST_RUN  = 3'h1;
  localparam ST_ROM  = 3'h2;
  localparam ST_DISC = 3'h3;
  localparam ST_END  = 3'h4;

  reg  [31:0] ctrl;
  reg  [1:0]  alt_sel;
  reg  [31:0] ival;
  reg         dph_wr;
  reg  [7:0]  dph_addr;
  reg  [2:0]  state;
  reg  [7:0]  found_cnt;
  reg  [63:0] shift;
  reg  [3:0]  byte_idx;
  reg         err_noresp;
  reg         more_dev;
  reg         res_pend;
  reg  [7:0]  res_code;
  reg         att_pend;
  reg  [7:0]  fifo [0:31];
  reg  [5:0]  wptr;
  reg  [5:0]  rptr;
  reg         ep1_busy;
  reg  [4:0]  ep1_pos;
  reg  [4:0]  ep1_len;
  reg  [31:0] rd_word;
  reg         next_res_req;
  reg  [7:0]  next_res_code;
  wire [7:0]  state_byte [0:15];
  genvar      gi;

  wire [5:0]  fill = wptr - rptr;
  wire        full = fill[5];
  wire        addr_ph = HSEL & HTRANS[1] & HREADY;
  wire        rd_ph = addr_ph & ~HWRITE;
  wire        ctrl_wr = dph_wr & (dph_addr == `SFR_CTRL_OFS);
  wire        alt_wr = dph_wr & (dph_addr == `SFR_ALT_OFS);
  wire        ival_wr = dph_wr & (dph_addr == `SFR_IVAL_OFS);
  wire [7:0]  lim = ctrl[`SFR_CTRL_CNT_LSB +: 8];
  wire        push_res = res_pend & ~full;
  wire        push_att = att_pend & ~full & ~res_pend;
  wire        pop = ep1_busy & (ep1_pos >= `SFR_STATE_BYTES);
  wire        search_ok = ~err_noresp & (found_cnt != 8'h00 | ~ctrl[`SFR_CTRL_SM_BIT]);
  wire        disc_due = ctrl[`SFR_CTRL_SM_BIT] & ctrl[`SFR_CTRL_RTS_BIT] & SRCH_MORE &
                         (lim != 8'h00);
  wire [4:0]  res_take = (fill > {1'b0, `SFR_RES_MAX}) ? `SFR_RES_MAX : fill[4:0];
  wire [31:0] stat_word = {10'h000, fill, found_cnt, 3'h0, more_dev, err_noresp, state};

  // state byte lanes
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_state
      assign state_byte[gi] = STATE_IN[gi * 8 +: 8];
    end
  endgenerate

  // register read mux
  always @* begin
    case ({HADDR[7:2], 2'b00})
      `SFR_CTRL_OFS: rd_word = {1'b0, ctrl[30:0]};
      `SFR_STAT_OFS: rd_word = stat_word;
      `SFR_ALT_OFS:  rd_word = {30'h0000_0000, alt_sel};
      `SFR_IVAL_OFS: rd_word = ival;
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  // result byte decision
  always @* begin
    next_res_req = 1'b0;
    next_res_code = `SFR_CODE_OK;
    if (~search_ok) begin
      // RULE_07 error code regardless of notify
      next_res_req = ~ctrl[`SFR_CTRL_ICP_BIT];
      next_res_code = err_noresp ? `SFR_CODE_NORESP : `SFR_CODE_DONE;
    end else begin
      // RULE_08 zero only with notify
      next_res_req = ~ctrl[`SFR_CTRL_ICP_BIT] & ctrl[`SFR_CTRL_NTF_BIT];
    end
  end

  // ahb slave, zero wait, always okay
  always @(posedge CLK) begin
    if (RST) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0000_0000;
      dph_wr <= 1'b0;
      dph_addr <= 8'h00;
    end else if (CE) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      dph_wr <= addr_ph & HWRITE;
      if (addr_ph)
        dph_addr <= {HADDR[7:2], 2'b00};
      if (rd_ph)
        HRDATA <= rd_word;
    end
  end

  // rule13 interval from alternate setting
  always @(posedge CLK) begin
    if (RST) begin
      alt_sel <= `SFR_ALT_RST;
      ival <= `SFR_IVAL_RST;
      POLL_MS <= 8'h00;
    end else if (CE) begin
      if (alt_wr)
        alt_sel <= HWDATA[1:0];
      if (ival_wr)
        ival <= HWDATA;
      // RULE_13 interval per setting
      POLL_MS <= ival[{alt_sel, 3'b000} +: 8];
    end
  end

  // search sequencer
  always @(posedge CLK) begin
    if (RST) begin
      ctrl <= `SFR_CTRL_RST;
      state <= ST_IDLE;
      found_cnt <= 8'h00;
      shift <= 64'h0;
      byte_idx <= 4'h0;
      err_noresp <= 1'b0;
      more_dev <= 1'b0;
      res_pend <= 1'b0;
      res_code <= `SFR_CODE_OK;
      SRCH_GO <= 1'b0;
      SRCH_CMD <= 8'h00;
      SRCH_MODE <= 1'b0;
      SRCH_STOP <= 1'b0;
      FLUSH <= 1'b0;
      OUT_VALID <= 1'b0;
      OUT_DATA <= 8'h00;
    end else if (CE) begin
      SRCH_GO <= 1'b0;
      FLUSH <= 1'b0;
      if (push_res)
        res_pend <= 1'b0;
      if (OUT_VALID & OUT_READY)
        OUT_VALID <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (ctrl_wr) begin
            ctrl <= HWDATA;
            // RULE_01 take command and count
            if (HWDATA[`SFR_CTRL_GO_BIT]) begin
              SRCH_GO <= 1'b1;
              SRCH_CMD <= HWDATA[`SFR_CTRL_CMD_LSB +: 8];
              // RULE_04 engine reads preloaded id
              SRCH_MODE <= HWDATA[`SFR_CTRL_SM_BIT];
              SRCH_STOP <= 1'b0;
              found_cnt <= 8'h00;
              err_noresp <= 1'b0;
              more_dev <= 1'b0;
              state <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          // RULE_09 any unanswered bit
          if (SRCH_NORESP)
            err_noresp <= 1'b1;
          if (DEV_FOUND) begin
            found_cnt <= found_cnt + 8'h01;
            // RULE_02 stop at limit
            // RULE_03 zero means no limit
            if ((lim != 8'h00) & (found_cnt + 8'h01 == lim))
              SRCH_STOP <= 1'b1;
            // RULE_05 access mode emits nothing
            if (ctrl[`SFR_CTRL_SM_BIT]) begin
              shift <= DEV_ROM;
              byte_idx <= 4'h0;
              state <= ST_ROM;
            end
          end else if (SRCH_END) begin
            more_dev <= SRCH_MORE;
            shift <= SRCH_DISC;
            byte_idx <= 4'h0;
            // RULE_06 discrepancy when limited
            if (disc_due)
              state <= ST_DISC;
            else
              state <= ST_END;
          end
        end
        ST_ROM, ST_DISC: begin
          if (SRCH_NORESP)
            err_noresp <= 1'b1;
          // RULE_06 eight byte blocks
          if (~OUT_VALID | OUT_READY) begin
            if (byte_idx == `SFR_ROM_BYTES) begin
              state <= (state == ST_DISC) ? ST_END : ST_RUN;
            end else begin
              OUT_VALID <= 1'b1;
              OUT_DATA <= shift[7:0];
              shift <= {8'h00, shift[63:8]};
              byte_idx <= byte_idx + 4'h1;
            end
          end
        end
        ST_END: begin
          // RULE_18 load only per command bits
          if (~res_pend) begin
            state <= ST_IDLE;
            SRCH_STOP <= 1'b0;
            res_pend <= next_res_req;
            res_code <= next_res_code;
            // RULE_10 flush on error
            FLUSH <= ctrl[`SFR_CTRL_F_BIT] & ~search_ok;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // result buffer, in order
  always @(posedge CLK) begin
    if (RST) begin
      wptr <= 6'h00;
      att_pend <= 1'b0;
    end else if (CE) begin
      // RULE_21 distinct attach byte
      if (ATTACH)
        att_pend <= 1'b1;
      else if (push_att)
        att_pend <= 1'b0;
      // RULE_22 append in order
      if (push_res | push_att) begin
        fifo[wptr[4:0]] <= push_res ? res_code : `SFR_CODE_ATTACH;
        wptr <= wptr + 6'h01;
      end
    end
  end

  // interrupt endpoint packet builder
  always @(posedge CLK) begin
    if (RST) begin
      rptr <= 6'h00;
      ep1_busy <= 1'b0;
      ep1_pos <= 5'h00;
      ep1_len <= 5'h00;
      EP1_VALID <= 1'b0;
      EP1_DATA <= 8'h00;
      EP1_LAST <= 1'b0;
    end else if (CE) begin
      EP1_VALID <= 1'b0;
      EP1_LAST <= 1'b0;
      // RULE_12 endpoint one only
      if (~ep1_busy & EP1_IN) begin
        ep1_busy <= 1'b1;
        ep1_pos <= 5'h00;
        // RULE_19 count from pending results
        ep1_len <= `SFR_STATE_BYTES + res_take - 5'h01;
      end else if (ep1_busy) begin
        EP1_VALID <= 1'b1;
        // RULE_16 results after state
        if (pop) begin
          EP1_DATA <= fifo[rptr[4:0]];
          rptr <= rptr + 6'h01;
        end else begin
          // RULE_15 state bytes first
          EP1_DATA <= state_byte[ep1_pos[3:0]];
        end
        // RULE_14 RULE_17 bounded, short end
        if (ep1_pos == ep1_len) begin
          EP1_LAST <= 1'b1;
          ep1_busy <= 1'b0;
        end else begin
          ep1_pos <= ep1_pos + 5'h01;
        end
      end
    end
  end
endmodule

// ===== tb/sfr_chk.sv
// Purpose: port checker for the search and feedback reporter
// Assumes: CE held high by the bench
// Notes: bound to sfr_top at the foot
`timescale 1ns/1ps
module sfr_chk (
  input wire         CLK,
  input wire         RST,
  input wire [31:0]  HWDATA,
  input wire         SRCH_GO,
  input wire         SRCH_MODE,
  input wire         SRCH_STOP,
  input wire         DEV_FOUND,
  input wire         OUT_VALID,
  input wire [127:0] STATE_IN,
  input wire         EP1_IN,
  input wire         EP1_VALID,
  input wire [7:0]   EP1_DATA,
  input wire         EP1_LAST
);
  reg [4:0] cnt;
  reg       busy;
  // byte index and packet busy tracking
  always @(posedge CLK) begin
    if (RST) begin
      cnt <= 5'h00;
      busy <= 1'b0;
    end else begin
      if (EP1_VALID)
        cnt <= EP1_LAST ? 5'h00 : cnt + 5'h01;
      if (EP1_VALID && EP1_LAST)
        busy <= 1'b0;
      else if (EP1_IN)
        busy <= 1'b1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_go_after_write: assert property ($rose(SRCH_GO) |-> $past(HWDATA[31]))
    else $error("search start without start bit");
  chk_stop_after_find: assert property ($rose(SRCH_STOP) |-> $past(DEV_FOUND))
    else $error("device limit flag without a find");
  chk_out_mode_only: assert property (OUT_VALID |-> SRCH_MODE)
    else $error("output bytes with search mode clear");
  chk_poll_latency: assert property (EP1_IN && !busy |-> ##2 EP1_VALID)
    else $error("poll answer late");
  chk_state_first: assert property (EP1_VALID && !cnt[4]
    |-> EP1_DATA == STATE_IN[{cnt[3:0], 3'h0} +: 8])
    else $error("state byte wrong");
  chk_last_min: assert property (EP1_LAST |-> EP1_VALID && cnt >= 5'h0F)
    else $error("packet ends too early");
  chk_full_stop: assert property (EP1_VALID && cnt == 5'h1F |-> EP1_LAST)
    else $error("packet longer than 32 bytes");
  chk_burst_steady: assert property (EP1_VALID && !EP1_LAST |=> EP1_VALID)
    else $error("gap inside packet");
  cover property (EP1_LAST && cnt == 5'h1F);
  cover property ($rose(SRCH_STOP));
  cover property (EP1_VALID && cnt == 5'h11 && EP1_DATA == 8'hA5);
endmodule
bind sfr_top sfr_chk u_chk (.CLK(CLK), .RST(RST), .HWDATA(HWDATA), .SRCH_GO(SRCH_GO),
  .SRCH_MODE(SRCH_MODE), .SRCH_STOP(SRCH_STOP), .DEV_FOUND(DEV_FOUND), .OUT_VALID(OUT_VALID),
  .STATE_IN(STATE_IN), .EP1_IN(EP1_IN), .EP1_VALID(EP1_VALID), .EP1_DATA(EP1_DATA),
  .EP1_LAST(EP1_LAST));

// ===== tb/sfr_host.sv
// Purpose: host model polling the interrupt endpoint
// Assumes: poll is a one-cycle request
// Notes: packet kept for the bench to inspect
`timescale 1ns/1ps
module sfr_host (
  input  wire       clk,
  input  wire       rst,
  input  wire       poll,
  input  wire       ep1_valid,
  input  wire [7:0] ep1_data,
  input  wire       ep1_last,
  output reg        ep1_in,
  output reg        done,
  output reg        att
);
  reg [7:0] pkt [0:31];
  reg [5:0] n;
  always @(posedge clk) begin
    ep1_in <= poll;
    if (rst || poll) begin
      n <= 6'h00;
      done <= 1'b0;
      att <= 1'b0;
    end else if (ep1_valid) begin
      pkt[n[4:0]] <= ep1_data;
      n <= n + 6'h01;
      done <= ep1_last;
      if (n >= 6'h10 && ep1_data == 8'hA5)
        att <= 1'b1;
    end
  end
endmodule

// ===== tb/tb_search_and_feedback_reporter.sv
// Purpose: register, search and feedback tests
// Assumes: zero wait bus slave, CE held high
// Notes: bench fakes the search engine
`timescale 1ns/1ps
module tb_search_and_feedback_reporter;
  reg          CLK = 0, RST = 1, HSEL = 0, HWRITE = 0, OUT_READY = 0, ATTACH = 0, pl = 0;
  reg          DEV_FOUND = 0, SRCH_END = 0, SRCH_MORE = 0, SRCH_NORESP = 0, fl = 0;
  reg  [1:0]   HTRANS = 2'h0;
  reg  [31:0]  HADDR = 32'h0, HWDATA = 32'h0, q;
  reg  [63:0]  DEV_ROM = 64'h0;
  wire [31:0]  HRDATA;
  wire [7:0]   SRCH_CMD, OUT_DATA, EP1_DATA, POLL_MS;
  wire         HREADYOUT, HRESP, SRCH_GO, SRCH_MODE, SRCH_STOP, FLUSH, OUT_VALID;
  wire         EP1_IN, EP1_VALID, EP1_LAST, done, att;
  integer      bad_count = 0, compares = 0, i, j, k;
  reg  [7:0]   oq [$];
  localparam [63:0]  ROM = 64'h1122_3344_5566_7788, DSC = 64'hF0E1_D2C3_B4A5_9687;
  localparam [127:0] ST = 128'h0F0E_0D0C_0B0A_0908_0706_0504_0302_0100;
  sfr_top dut (.CLK(CLK), .RST(RST), .CE(1'b1), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SRCH_GO(SRCH_GO), .SRCH_CMD(SRCH_CMD),
    .SRCH_MODE(SRCH_MODE), .SRCH_STOP(SRCH_STOP), .DEV_FOUND(DEV_FOUND), .DEV_ROM(DEV_ROM),
    .SRCH_END(SRCH_END), .SRCH_MORE(SRCH_MORE), .SRCH_DISC(DSC), .SRCH_NORESP(SRCH_NORESP),
    .FLUSH(FLUSH), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_READY(OUT_READY),
    .ATTACH(ATTACH), .STATE_IN(ST), .EP1_IN(EP1_IN), .EP1_VALID(EP1_VALID),
    .EP1_DATA(EP1_DATA), .EP1_LAST(EP1_LAST), .POLL_MS(POLL_MS));
  sfr_host host (.clk(CLK), .rst(RST), .poll(pl), .ep1_valid(EP1_VALID), .ep1_data(EP1_DATA),
    .ep1_last(EP1_LAST), .ep1_in(EP1_IN), .done(done), .att(att));
  always #25 CLK = ~CLK;
  always @(posedge CLK) begin
    if (OUT_VALID && OUT_READY)
      oq.push_back(OUT_DATA);
    if (FLUSH)
      fl <= 1;
    OUT_READY <= ~OUT_READY;
  end
  task tally_and_finish;
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string s, input [31:0] e, input [31:0] g);
    compares = compares + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task tick(inout integer c);
    @(posedge CLK);
    c = c + 1;
    if (c > 400) begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  endtask
  task bus(input [7:0] a, input w, input [31:0] d);
    integer c;
    c = 0;
    HSEL <= 1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    tick(c);
    while (HREADYOUT !== 1'b1) tick(c);
    HSEL <= 0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    tick(c);
    while (HREADYOUT !== 1'b1) tick(c);
    q = HRDATA;
  endtask
  task run(input [31:0] c, input integer nf, input mr, input nr);
    oq.delete();
    bus(8'h00, 1, c | 32'h8000_0000);
    k = 0;
    while (SRCH_GO !== 1'b1) tick(k);
    for (j = 0; j < nf; j = j + 1) begin
      DEV_FOUND <= 1;
      DEV_ROM <= ROM + j;
      tick(k);
      DEV_FOUND <= 0;
      while (c[16] && oq.size() < 8 * j + 8) tick(k);
      repeat (3) tick(k);
    end
    if (c[15:8] != 0 && nf >= c[15:8]) chk("stop", 1, SRCH_STOP);
    if (c[15:8] == 0) chk("stop", 0, SRCH_STOP);
    SRCH_NORESP <= nr;
    tick(k);
    SRCH_NORESP <= 0;
    SRCH_END <= 1;
    SRCH_MORE <= mr;
    tick(k);
    SRCH_END <= 0;
    SRCH_MORE <= 0;
    q = 1;
    while (q[2:0] !== 3'h0) begin
      bus(8'h04, 0, 0);
      tick(k);
    end
    while (c[17] && mr && oq.size() < 8 * nf + 8) tick(k);
  endtask
  task poll(input integer n);
    pl <= 1;
    @(posedge CLK);
    pl <= 0;
    @(posedge CLK);
    k = 0;
    while (done !== 1'b1) tick(k);
    chk("ep1_len", n, host.n);
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RST <= 0;
    @(posedge CLK);
    bus(8'h0C, 0, 0);
    chk("ival", 32'h1010_0A01, q);
    chk("hresp", 0, HRESP);
    chk("poll_ms", 8'h01, POLL_MS);
    bus(8'h10, 1, 32'hFFFF_FFFF);
    bus(8'h10, 0, 0);
    chk("unmapped", 0, q);
    for (i = 1; i < 4; i = i + 1) begin
      bus(8'h08, 1, i);
      bus(8'h08, 0, 0);
      chk("alt", i, q);
      chk("poll_ms", (32'h1010_0A01 >> (8 * i)) & 32'hFF, POLL_MS);
    end
    run(32'h0008_00F0, 3, 0, 0);
    chk("cmd", 8'hF0, SRCH_CMD);
    chk("stat", 32'h0001_0300, q);
    chk("out_none", 0, oq.size());
    poll(17);
    chk("res_ok", 8'h00, host.pkt[16]);
    run(32'h0003_01EC, 1, 1, 0);
    chk("out_len", 16, oq.size());
    chk("cmd", 8'hEC, SRCH_CMD);
    chk("stat", 32'h0000_0110, q);
    for (j = 0; j < 8; j = j + 1) begin
      chk("rom", ROM[8 * j +: 8], oq[j]);
      chk("disc", DSC[8 * j +: 8], oq[8 + j]);
    end
    poll(16);
    run(32'h0010_00F0, 0, 0, 1);
    chk("flush", 1, fl);
    chk("stat", 32'h0001_0008, q);
    ATTACH <= 1;
    @(posedge CLK);
    ATTACH <= 0;
    poll(18);
    chk("res_nr", 8'h81, host.pkt[16]);
    chk("attach", 8'hA5, host.pkt[17]);
    chk("att_seen", 1, att);
    run(32'h000D_00F0, 0, 0, 0);
    poll(16);
    run(32'h0001_00F0, 0, 0, 0);
    poll(17);
    chk("res_done", 8'h80, host.pkt[16]);
    for (i = 0; i < 17; i = i + 1)
      run(32'h0008_00F0, 0, 0, 0);
    poll(32);
    poll(17);
    tally_and_finish;
  end
endmodule
